// File: adcseq_pkg.sv
// constants shared by the conversion sequencer files
package adcseq_pkg;
  // register byte offsets
  localparam logic [7:0] ADCSEQ_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] ADCSEQ_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] ADCSEQ_OFF_CTRL2 = 8'h08;
  localparam logic [7:0] ADCSEQ_OFF_ACQ = 8'h0C;
  localparam logic [7:0] ADCSEQ_OFF_DELAY = 8'h10;
  localparam logic [7:0] ADCSEQ_OFF_RES_HIGH = 8'h14;
  localparam logic [7:0] ADCSEQ_OFF_RES_LOW = 8'h18;
  localparam logic [7:0] ADCSEQ_OFF_CMP_HIGH = 8'h1C;
  localparam logic [7:0] ADCSEQ_OFF_CMP_LOW = 8'h20;
  localparam logic [7:0] ADCSEQ_OFF_BRAKE = 8'h24;
  localparam logic [7:0] ADCSEQ_OFF_INTEN = 8'h28;
  // control 0 fields
  localparam int ADCSEQ_C0_DONE = 7;
  localparam int ADCSEQ_C0_BUSY = 6;
  localparam int ADCSEQ_C0_SRC_LO = 4;
  localparam int ADCSEQ_C0_CH_LO = 0;
  // control 1 fields
  localparam int ADCSEQ_C1_VREF = 7;
  localparam int ADCSEQ_C1_DIV_LO = 4;
  localparam int ADCSEQ_C1_COND_LO = 2;
  localparam int ADCSEQ_C1_HWTRIG = 1;
  localparam int ADCSEQ_C1_POWER = 0;
  localparam logic [7:0] ADCSEQ_C1_RESET = 8'h20;
  // control 2 fields
  localparam int ADCSEQ_C2_BRAKE_LINK = 7;
  localparam int ADCSEQ_C2_POLARITY = 6;
  localparam int ADCSEQ_C2_CMP_EN = 5;
  localparam int ADCSEQ_C2_CMP_OUT = 4;
  // brake and interrupt-enable fields
  localparam int ADCSEQ_BRAKE_FLAG = 7;
  localparam int ADCSEQ_IE_CONV = 0;
  localparam int ADCSEQ_IE_BRAKE = 1;
  // trigger source and condition codes
  localparam logic [1:0] ADCSEQ_SRC_PWM0 = 2'h0;
  localparam logic [1:0] ADCSEQ_SRC_PWM2 = 2'h1;
  localparam logic [1:0] ADCSEQ_SRC_PWM4 = 2'h2;
  localparam logic [1:0] ADCSEQ_SRC_PIN = 2'h3;
  localparam logic [1:0] ADCSEQ_COND_FALL = 2'h0;
  localparam logic [1:0] ADCSEQ_COND_RISE = 2'h1;
  localparam logic [1:0] ADCSEQ_COND_CENTRE = 2'h2;
  localparam logic [1:0] ADCSEQ_COND_END = 2'h3;
  // timing in converter clock ticks
  localparam logic [8:0] ADCSEQ_ACQ_BASE = 9'h006;
  localparam logic [1:0] ADCSEQ_BIT_TICKS_M1 = 2'h3;
  localparam int ADCSEQ_RES_BITS = 10;
  // bus responses
  localparam logic [1:0] ADCSEQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] ADCSEQ_RESP_SLVERR = 2'h2;
endpackage

// File: adcseq_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module adcseq_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clock_enable,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      meta_reg <= '0;
      o_sync <= '0;
    end
    else if (i_clock_enable)
    begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule // adcseq_sync

// File: adcseq_sar.sv
// acquisition timer and successive-approximation stepper
`timescale 1ns/1ps
module adcseq_sar
  import adcseq_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clock_enable,
  input wire logic i_adc_tick,
  input wire logic i_start,
  input wire logic [7:0] i_acq_extension,
  input wire logic i_comparator_high,
  output logic o_sampling,
  output logic [9:0] o_dac_code,
  output logic o_done,
  output logic [9:0] o_result
);
  typedef enum logic [1:0] {ADCSEQ_IDLE, ADCSEQ_SAMPLE, ADCSEQ_CONVERT}
    adcseq_sar_e;
  adcseq_sar_e state_reg;
  logic [8:0] acq_cnt_reg;
  logic [3:0] bit_idx_reg;
  logic [1:0] tick_cnt_reg;
  logic [9:0] trial_bit;
  logic [9:0] decided;

  assign trial_bit = 10'h001 << bit_idx_reg;
  // comparator high means input is above the trial level: keep the bit
  assign decided = i_comparator_high ? o_dac_code : (o_dac_code & ~trial_bit);
  assign o_sampling = (state_reg == ADCSEQ_SAMPLE);

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state_reg <= ADCSEQ_IDLE;
      acq_cnt_reg <= 9'h000;
      bit_idx_reg <= 4'h0;
      tick_cnt_reg <= 2'h0;
      o_dac_code <= 10'h000;
      o_done <= 1'b0;
      o_result <= 10'h000;
    end
    else if (i_clock_enable)
    begin
      o_done <= 1'b0;
      case (state_reg)
        ADCSEQ_IDLE:
        begin
          if (i_start)
          begin
            acq_cnt_reg <= ADCSEQ_ACQ_BASE + {1'b0, i_acq_extension};
            state_reg <= ADCSEQ_SAMPLE;
          end
        end
        ADCSEQ_SAMPLE:
        begin
          if (i_adc_tick)
          begin
            acq_cnt_reg <= acq_cnt_reg - 9'h001;
            if (acq_cnt_reg == 9'h001)
            begin
              state_reg <= ADCSEQ_CONVERT;
              bit_idx_reg <= 4'h9;
              tick_cnt_reg <= 2'h0;
              o_dac_code <= 10'h200;
            end
          end
        end
        ADCSEQ_CONVERT:
        begin
          if (i_adc_tick)
          begin
            tick_cnt_reg <= tick_cnt_reg + 2'h1;
            // several ticks per bit so the synchronised comparator settles
            if (tick_cnt_reg == ADCSEQ_BIT_TICKS_M1)
            begin
              if (bit_idx_reg == 4'h0)
              begin
                o_result <= decided;
                o_done <= 1'b1;
                state_reg <= ADCSEQ_IDLE;
              end
              else
              begin
                o_dac_code <= decided | (trial_bit >> 1);
                bit_idx_reg <= bit_idx_reg - 4'h1;
              end
            end
          end
        end
        default:
        begin
          state_reg <= ADCSEQ_IDLE;
        end
      endcase
    end
  end
endmodule // adcseq_sar

// File: adcseq_top.sv
// conversion sequencer: bus registers, triggers, delay, compare and brake
// Contract
// - software powers converter on first; converter runs only while bit set
// - reference taken from supply or external pin per select bit
// - four-bit field picks which input feeds the sample-and-hold
// - writing start bit begins one conversion; reads one while busy
// - completion clears busy, sets done flag, interrupts when enabled
// - result upper eight bits to high register, low two to low register
// - ten-bit unsigned code proportional to input over reference
// - sampling lasts six converter clocks plus extension, 6 to 261
// - enabled hardware trigger from pwm or start pin starts, sets busy
// - two-bit source field and two-bit condition field choose trigger
// - programmable delay between trigger point and conversion start
// - start requests while busy are dropped silently, no error
// - compare enabled: each completed result checked against ten-bit threshold
// - read-only compare output shows outcome, optionally inverted
// - link enabled and compare output rising raises brake event
// - brake flag set by brake pin or compare event; software clears
// - source 00,01,10 pick pwm 0,2,4; 11 picks start pin
// - condition 00 fall, 01 rise, 10 centre, 11 end point
// - no new conversion while done flag is still set
`timescale 1ns/1ps
module adcseq_top
  import adcseq_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clock_enable,
  // axi4-lite slave
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // pwm unit, same clock
  input wire logic [2:0] i_pwm_level,
  input wire logic i_pwm_centre_point,
  input wire logic i_pwm_end_point,
  input wire logic i_pwm_centre_aligned,
  input wire logic i_brake_pin_event,
  output logic o_fault_brake,
  // pins
  input wire logic i_external_start_pin,
  input wire logic i_comparator_high,
  // analog front end control
  output logic o_converter_power_on,
  output logic o_reference_source_select,
  output logic [3:0] o_input_channel_select,
  output logic o_input_connect,
  output logic o_sample_hold,
  output logic [9:0] o_dac_code,
  // interrupt requests
  output logic o_conversion_irq,
  output logic o_brake_irq
);
  logic [3:0] input_channel_select_reg;
  logic [1:0] trigger_source_select_reg;
  logic conversion_start_busy_reg;
  logic conversion_done_flag_reg;
  logic reference_source_select_reg;
  logic [2:0] clock_divider_reg;
  logic [1:0] trigger_condition_select_reg;
  logic hardware_trigger_enable_reg;
  logic converter_power_on_reg;
  logic compare_brake_link_enable_reg;
  logic compare_output_polarity_reg;
  logic compare_enable_reg;
  logic compare_output_reg;
  logic [7:0] acquisition_extension_reg;
  logic [9:0] trigger_delay_reg;
  logic [7:0] result_high_byte_reg;
  logic [1:0] result_low_bits_reg;
  logic [7:0] compare_threshold_high_reg;
  logic [1:0] compare_threshold_low_reg;
  logic brake_event_flag_reg;
  logic conversion_irq_enable_reg;
  logic brake_interrupt_enable_reg;
  logic [6:0] div_cnt_reg;
  logic [6:0] div_limit;
  logic adc_tick;
  logic ext_start_sync;
  logic comparator_sync;
  logic selected_level;
  logic selected_prev_reg;
  logic trigger_hit;
  logic hw_trigger;
  logic delay_active_reg;
  logic [9:0] delay_cnt_reg;
  logic delay_expired;
  logic sw_start;
  logic start_request;
  logic start_accept;
  logic sar_done;
  logic [9:0] sar_result;
  logic [9:0] full_result;
  logic [9:0] threshold;
  logic compare_raw;
  logic compare_event;
  // bus state
  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic write_fire;
  logic write_mapped;
  logic read_mapped;
  logic [7:0] read_byte;
  logic wr_low;

  adcseq_sync #(.WIDTH(2)) u_pin_sync (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_clock_enable(i_clock_enable),
    .i_async({i_external_start_pin, i_comparator_high}),
    .o_sync({ext_start_sync, comparator_sync})
  );

  adcseq_sar u_sar (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_clock_enable(i_clock_enable),
    .i_adc_tick(adc_tick),
    .i_start(start_accept),
    .i_acq_extension(acquisition_extension_reg),
    .i_comparator_high(comparator_sync),
    .o_sampling(o_sample_hold),
    .o_dac_code(o_dac_code),
    .o_done(sar_done),
    .o_result(sar_result)
  );

  // converter clock as a tick of the system clock, divided by 2^n
  assign div_limit = 7'((8'h01 << clock_divider_reg) - 8'h01);
  assign adc_tick = converter_power_on_reg & (div_cnt_reg >= div_limit);

  // power-off clear sits inside the enable so a frozen block keeps its count
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      div_cnt_reg <= 7'h00;
    else if (i_clock_enable)
      div_cnt_reg <= (adc_tick || !converter_power_on_reg) ? 7'h00 :
        div_cnt_reg + 7'h01;
  end

  assign o_converter_power_on = converter_power_on_reg;
  assign o_input_connect = converter_power_on_reg;
  assign o_reference_source_select = reference_source_select_reg;
  assign o_input_channel_select = input_channel_select_reg;

  // trigger source and condition decode
  always_comb
  begin
    case (trigger_source_select_reg)
      ADCSEQ_SRC_PWM0: selected_level = i_pwm_level[0];
      ADCSEQ_SRC_PWM2: selected_level = i_pwm_level[1];
      ADCSEQ_SRC_PWM4: selected_level = i_pwm_level[2];
      default: selected_level = ext_start_sync;
    endcase
  end

  always_comb
  begin
    case (trigger_condition_select_reg)
      ADCSEQ_COND_FALL: trigger_hit = selected_prev_reg & ~selected_level;
      ADCSEQ_COND_RISE: trigger_hit = ~selected_prev_reg & selected_level;
      ADCSEQ_COND_CENTRE: trigger_hit = i_pwm_centre_point &
        i_pwm_centre_aligned & (trigger_source_select_reg != ADCSEQ_SRC_PIN);
      ADCSEQ_COND_END: trigger_hit = i_pwm_end_point &
        i_pwm_centre_aligned & (trigger_source_select_reg != ADCSEQ_SRC_PIN);
      default: trigger_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      selected_prev_reg <= 1'b0;
    else if (i_clock_enable)
      selected_prev_reg <= selected_level;
  end

  assign hw_trigger = hardware_trigger_enable_reg & trigger_hit;

  // trigger delay counts converter ticks; a trigger during a pending
  // delay or a conversion is dropped rather than queued
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      delay_active_reg <= 1'b0;
      delay_cnt_reg <= 10'h000;
    end
    else if (i_clock_enable)
    begin
      if (!delay_active_reg)
      begin
        if (hw_trigger && trigger_delay_reg != 10'h000 &&
            !conversion_start_busy_reg && !conversion_done_flag_reg)
        begin
          delay_active_reg <= 1'b1;
          delay_cnt_reg <= trigger_delay_reg;
        end
      end
      else if (adc_tick)
      begin
        delay_cnt_reg <= delay_cnt_reg - 10'h001;
        if (delay_cnt_reg == 10'h001)
          delay_active_reg <= 1'b0;
      end
    end
  end

  assign delay_expired = delay_active_reg & adc_tick &
    (delay_cnt_reg == 10'h001);
  assign start_request = sw_start | delay_expired |
    (hw_trigger & (trigger_delay_reg == 10'h000) & ~delay_active_reg);
  assign start_accept = start_request & converter_power_on_reg &
    ~conversion_start_busy_reg & ~conversion_done_flag_reg;

  // result assembly and comparator
  assign full_result = {result_high_byte_reg, result_low_bits_reg};
  assign threshold = {compare_threshold_high_reg, compare_threshold_low_reg};
  assign compare_raw = (sar_result >= threshold);
  assign compare_event = sar_done & compare_enable_reg &
    compare_brake_link_enable_reg & ~compare_output_reg &
    (compare_raw ^ compare_output_polarity_reg);

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      result_high_byte_reg <= 8'h00;
      result_low_bits_reg <= 2'h0;
      compare_output_reg <= 1'b0;
    end
    else if (i_clock_enable && sar_done)
    begin
      result_high_byte_reg <= sar_result[9:2];
      result_low_bits_reg <= sar_result[1:0];
      if (compare_enable_reg)
        compare_output_reg <= compare_raw ^ compare_output_polarity_reg;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      o_fault_brake <= 1'b0;
    else if (i_clock_enable)
      o_fault_brake <= compare_event;
  end

  assign o_conversion_irq = conversion_done_flag_reg &
    conversion_irq_enable_reg;
  assign o_brake_irq = brake_event_flag_reg & brake_interrupt_enable_reg;

  // axi4-lite write path: address and data held independently
  assign o_s_axi_awready = ~aw_held_reg & ~o_s_axi_bvalid;
  assign o_s_axi_wready = ~w_held_reg & ~o_s_axi_bvalid;
  assign write_fire = aw_held_reg & w_held_reg & i_clock_enable;
  assign wr_low = write_fire & wstrb_reg[0];

  always_comb
  begin
    case (awaddr_reg & 8'hFC)
      ADCSEQ_OFF_CTRL0, ADCSEQ_OFF_CTRL1, ADCSEQ_OFF_CTRL2, ADCSEQ_OFF_ACQ,
      ADCSEQ_OFF_DELAY, ADCSEQ_OFF_RES_HIGH, ADCSEQ_OFF_RES_LOW,
      ADCSEQ_OFF_CMP_HIGH, ADCSEQ_OFF_CMP_LOW, ADCSEQ_OFF_BRAKE,
      ADCSEQ_OFF_INTEN: write_mapped = 1'b1;
      default: write_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= ADCSEQ_RESP_OKAY;
    end
    else if (i_clock_enable)
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= i_s_axi_wdata;
        wstrb_reg <= i_s_axi_wstrb;
      end
      if (write_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= write_mapped ? ADCSEQ_RESP_OKAY : ADCSEQ_RESP_SLVERR;
      end
      else if (o_s_axi_bvalid && i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
    end
  end

  assign sw_start = wr_low & (awaddr_reg == ADCSEQ_OFF_CTRL0) &
    wdata_reg[ADCSEQ_C0_BUSY];

  // status flags: hardware set beats software clear in the same cycle
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      conversion_start_busy_reg <= 1'b0;
      conversion_done_flag_reg <= 1'b0;
      brake_event_flag_reg <= 1'b0;
    end
    else if (i_clock_enable)
    begin
      if (start_accept)
        conversion_start_busy_reg <= 1'b1;
      else if (sar_done)
        conversion_start_busy_reg <= 1'b0;
      if (sar_done)
        conversion_done_flag_reg <= 1'b1;
      else if (wr_low && awaddr_reg == ADCSEQ_OFF_CTRL0 &&
               !wdata_reg[ADCSEQ_C0_DONE])
        conversion_done_flag_reg <= 1'b0;
      if (i_brake_pin_event || compare_event)
        brake_event_flag_reg <= 1'b1;
      else if (wr_low && awaddr_reg == ADCSEQ_OFF_BRAKE &&
               !wdata_reg[ADCSEQ_BRAKE_FLAG])
        brake_event_flag_reg <= 1'b0;
    end
  end

  // plain control registers
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      input_channel_select_reg <= 4'h0;
      trigger_source_select_reg <= 2'h0;
      {reference_source_select_reg, clock_divider_reg,
       trigger_condition_select_reg, hardware_trigger_enable_reg,
       converter_power_on_reg} <= ADCSEQ_C1_RESET;
      compare_brake_link_enable_reg <= 1'b0;
      compare_output_polarity_reg <= 1'b0;
      compare_enable_reg <= 1'b0;
      acquisition_extension_reg <= 8'h00;
      trigger_delay_reg <= 10'h000;
      compare_threshold_high_reg <= 8'h00;
      compare_threshold_low_reg <= 2'h0;
      conversion_irq_enable_reg <= 1'b0;
      brake_interrupt_enable_reg <= 1'b0;
    end
    else if (wr_low)
    begin
      case (awaddr_reg)
        ADCSEQ_OFF_CTRL0:
        begin
          input_channel_select_reg <= wdata_reg[ADCSEQ_C0_CH_LO +: 4];
          trigger_source_select_reg <= wdata_reg[ADCSEQ_C0_SRC_LO +: 2];
        end
        ADCSEQ_OFF_CTRL1:
        begin
          reference_source_select_reg <= wdata_reg[ADCSEQ_C1_VREF];
          clock_divider_reg <= wdata_reg[ADCSEQ_C1_DIV_LO +: 3];
          trigger_condition_select_reg <= wdata_reg[ADCSEQ_C1_COND_LO +: 2];
          hardware_trigger_enable_reg <= wdata_reg[ADCSEQ_C1_HWTRIG];
          converter_power_on_reg <= wdata_reg[ADCSEQ_C1_POWER];
        end
        ADCSEQ_OFF_CTRL2:
        begin
          compare_brake_link_enable_reg <= wdata_reg[ADCSEQ_C2_BRAKE_LINK];
          compare_output_polarity_reg <= wdata_reg[ADCSEQ_C2_POLARITY];
          compare_enable_reg <= wdata_reg[ADCSEQ_C2_CMP_EN];
        end
        ADCSEQ_OFF_ACQ: acquisition_extension_reg <= wdata_reg[7:0];
        ADCSEQ_OFF_DELAY: trigger_delay_reg <= wdata_reg[9:0];
        ADCSEQ_OFF_CMP_HIGH: compare_threshold_high_reg <= wdata_reg[7:0];
        ADCSEQ_OFF_CMP_LOW: compare_threshold_low_reg <= wdata_reg[1:0];
        ADCSEQ_OFF_INTEN:
        begin
          conversion_irq_enable_reg <= wdata_reg[ADCSEQ_IE_CONV];
          brake_interrupt_enable_reg <= wdata_reg[ADCSEQ_IE_BRAKE];
        end
        default:
        begin
        end
      endcase
    end
  end

  // axi4-lite read path
  assign o_s_axi_arready = ~o_s_axi_rvalid;

  always_comb
  begin
    read_mapped = 1'b1;
    case (i_s_axi_araddr & 8'hFC)
      ADCSEQ_OFF_CTRL0: read_byte = {conversion_done_flag_reg,
        conversion_start_busy_reg, trigger_source_select_reg,
        input_channel_select_reg};
      ADCSEQ_OFF_CTRL1: read_byte = {reference_source_select_reg,
        clock_divider_reg, trigger_condition_select_reg,
        hardware_trigger_enable_reg, converter_power_on_reg};
      ADCSEQ_OFF_CTRL2: read_byte = {compare_brake_link_enable_reg,
        compare_output_polarity_reg, compare_enable_reg,
        compare_output_reg, 4'h0};
      ADCSEQ_OFF_ACQ: read_byte = acquisition_extension_reg;
      ADCSEQ_OFF_DELAY: read_byte = trigger_delay_reg[7:0];
      ADCSEQ_OFF_RES_HIGH: read_byte = full_result[9:2];
      ADCSEQ_OFF_RES_LOW: read_byte = {6'h00, full_result[1:0]};
      ADCSEQ_OFF_CMP_HIGH: read_byte = compare_threshold_high_reg;
      ADCSEQ_OFF_CMP_LOW: read_byte = {6'h00, compare_threshold_low_reg};
      ADCSEQ_OFF_BRAKE: read_byte = {brake_event_flag_reg, 7'h00};
      ADCSEQ_OFF_INTEN: read_byte = {6'h00, brake_interrupt_enable_reg,
        conversion_irq_enable_reg};
      default:
      begin
        read_byte = 8'h00;
        read_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= ADCSEQ_RESP_OKAY;
    end
    else if (i_clock_enable)
    begin
      if (i_s_axi_arvalid && o_s_axi_arready)
      begin
        o_s_axi_rvalid <= 1'b1;
        // delay register is ten bits wide; its top bits ride above the byte
        o_s_axi_rdata <= ((i_s_axi_araddr & 8'hFC) == ADCSEQ_OFF_DELAY) ?
          {22'h00_0000, trigger_delay_reg} : {24'h00_0000, read_byte};
        o_s_axi_rresp <= read_mapped ? ADCSEQ_RESP_OKAY : ADCSEQ_RESP_SLVERR;
      end
      else if (o_s_axi_rvalid && i_s_axi_rready)
        o_s_axi_rvalid <= 1'b0;
    end
  end
endmodule // adcseq_top

// File: adcseq_monitor.sv
// port checker for the conversion sequencer
`timescale 1ns/1ps
module adcseq_monitor (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_s_axi_arvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_rready,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_bvalid,
  input wire logic o_s_axi_rvalid,
  input wire logic o_converter_power_on,
  input wire logic o_input_connect,
  input wire logic o_sample_hold,
  input wire logic o_fault_brake,
  input wire logic o_conversion_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence s_sample6;
    o_sample_hold [*6];
  endsequence
  property p_conn; o_sample_hold |-> o_input_connect; endproperty
  a_conn: assert property (p_conn) else $error("sampling unlinked");
  property p_pwr; $rose(o_sample_hold) |-> o_converter_power_on; endproperty
  a_pwr: assert property (p_pwr) else $error("sampling unpowered");
  property p_acq; $rose(o_sample_hold) |-> s_sample6; endproperty
  a_acq: assert property (p_acq) else $error("sampling too short");
  property p_irq; $rose(o_conversion_irq) |-> !o_sample_hold; endproperty
  a_irq: assert property (p_irq) else $error("irq while sampling");
  property p_brk; o_fault_brake |=> !o_fault_brake; endproperty
  a_brk: assert property (p_brk) else $error("brake not a pulse");
  property p_rsp; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("read answer late");
  property p_rh; o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid;
  endproperty
  a_rh: assert property (p_rh) else $error("read answer dropped");
  property p_bh; o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid;
  endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped");
endmodule // adcseq_monitor

// File: adcseq_pwm_model.sv
// pwm unit and start pin stand-in, same clock as the sequencer
`timescale 1ns/1ps
module adcseq_pwm_model (
  input wire logic i_clock,
  input wire logic i_pin_go,
  output logic [2:0] o_pwm_level,
  output logic o_centre_point,
  output logic o_end_point,
  output logic o_start_pin
);
  logic [6:0] count_reg = 7'h00;
  always_ff @(posedge i_clock)
    count_reg <= count_reg + 7'h01;
  always_ff @(posedge i_clock)
    o_start_pin <= i_pin_go;
  // channels at three rates: level 2 toggles every 16 counts, level 1 every 32, level 0 every 64
  assign o_pwm_level = {count_reg[4], count_reg[5], count_reg[6]};
  assign o_centre_point = (count_reg == 7'h3F);
  assign o_end_point = (count_reg == 7'h7F);
endmodule // adcseq_pwm_model

// File: adc_conversion_sequencer_test.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 1, arv = 0, rry = 1, go = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, q, rdata;
  logic [1:0] rs, rresp;
  logic [9:0] vin = 0, dac;
  logic awr, wr_rdy, bv_o, arr, rv_o, cpt, ept, pin, birq;
  logic [2:0] lvl;
  logic [3:0] chs;
  int num_errors = 0, check_count = 0;
  // ch, input, expected high and low result; band-gap ch 15 unused
  logic [31:0] rows [4] = '{32'h33FF_FF03, 32'h0000_0000, 32'h52A6_A902,
    32'h9155_5501};
  adcseq_top dut (.i_clock(clk), .i_reset(rst), .i_clock_enable(1'b1),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr_rdy), .o_s_axi_bresp(), .o_s_axi_bvalid(bv_o),
    .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rv_o), .i_s_axi_rready(rry), .i_pwm_level(lvl),
    .i_pwm_centre_point(cpt), .i_pwm_end_point(ept),
    .i_pwm_centre_aligned(1'b1), .i_brake_pin_event(1'b0),
    .o_fault_brake(), .i_external_start_pin(pin),
    .i_comparator_high(vin >= dac), .o_converter_power_on(),
    .o_reference_source_select(), .o_input_channel_select(chs),
    .o_input_connect(), .o_sample_hold(), .o_dac_code(dac),
    .o_conversion_irq(), .o_brake_irq(birq));
  adcseq_pwm_model pwm (.i_clock(clk), .i_pin_go(go), .o_pwm_level(lvl),
    .o_centre_point(cpt), .o_end_point(ept), .o_start_pin(pin));
  always #12.5 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ra, rw, bv;
    awa <= a;
    wd <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bv = 1'b0;
    while (!bv)
    begin
      @(negedge clk);
      ra = awr;
      rw = wr_rdy;
      bv = bv_o;
      @(posedge clk);
      if (ra) awv <= 1'b0;
      if (rw) wv <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ra, rv;
    ara <= a;
    arv <= 1'b1;
    rv = 1'b0;
    while (!rv)
    begin
      @(negedge clk);
      ra = arr;
      rv = rv_o;
      q = rdata;
      rs = rresp;
      @(posedge clk);
      if (ra) arv <= 1'b0;
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [7:0] e);
    check_count++;
    if (g !== {24'h00_0000, e})
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wdone;
    q = 32'h0000_0000;
    while (q[7] !== 1'b1)
      rd(8'h00);
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(8'h04);
    chk(q, 8'h20);
    rd(8'h3C);
    chk({30'h0000_0000, rs}, 8'h02);
    wr(8'h04, 8'h21);
    for (int i = 0; i < 4; i++)
    begin
      vin <= rows[i][25:16];
      wr(8'h00, {4'h4, rows[i][31:28]});
      rd(8'h00);
      chk(q, {4'h4, rows[i][31:28]});
      chk({28'h000_0000, chs}, {4'h0, rows[i][31:28]});
      wdone;
      rd(8'h14);
      chk(q, rows[i][15:8]);
      rd(8'h18);
      chk(q, rows[i][7:0]);
      wr(8'h00, {4'h0, rows[i][31:28]});
    end
    // done kept set: the start must be dropped
    wr(8'h00, 8'h43);
    wdone;
    wr(8'h00, 8'hC3);
    rd(8'h00);
    chk(q, 8'h83);
    wr(8'h1C, 8'h40);
    wr(8'h08, 8'hA0);
    wr(8'h28, 8'h03);
    vin <= 10'h200;
    wr(8'h00, 8'h03);
    wr(8'h00, 8'h43);
    wdone;
    rd(8'h08);
    chk(q, 8'hB0);
    rd(8'h24);
    chk(q, 8'h80);
    chk({31'h0000_0000, birq}, 8'h01);
    wr(8'h00, 8'h30);
    wr(8'h04, 8'h27);
    go <= 1'b1;
    repeat (8) @(posedge clk);
    rd(8'h00);
    chk(q, 8'h70);
    go <= 1'b0;
    wdone;
    wr(8'h00, 8'h00);
    repeat (130) @(posedge clk);
    rd(8'h00);
    chk(q, 8'h40);
    test_done;
  end
endmodule // adc_conversion_sequencer_test
bind adcseq_top adcseq_monitor mon (.i_clock(i_clock), .i_reset(i_reset),
  .i_s_axi_arvalid(i_s_axi_arvalid), .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_rready(i_s_axi_rready), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_rvalid(o_s_axi_rvalid),
  .o_converter_power_on(o_converter_power_on),
  .o_input_connect(o_input_connect), .o_sample_hold(o_sample_hold),
  .o_fault_brake(o_fault_brake), .o_conversion_irq(o_conversion_irq));
